//--- pkg/dcfm_pkg.sv
// shared constants and types of the mailbox fifo
`default_nettype none
package dcfm_pkg;
  // ==================================================================
  // widths and depths
  localparam int DATA_W = 36; // word width
  localparam int DEPTH_DEF = 512; // smallest variant
  localparam int STAGE_DEPTH = 8; // staging buffer words
  localparam int STAGE_SLACK = 4; // room kept for flag lag
  // ==================================================================
  // preset almost offsets, chosen at reset
  localparam int PRESET_A = 8;
  localparam int PRESET_B = 16;
  // ==================================================================
  // reset levels of the flags
  localparam logic RST_ROOM = 1'b0;
  localparam logic RST_VALID = 1'b0;
  localparam logic RST_NEAR_EMPTY_N = 1'b0;
  localparam logic RST_NEAR_FULL_N = 1'b1;
  localparam logic RST_MAIL_N = 1'b1;
  // ==================================================================
  // offset programming methods
  typedef enum logic [1:0] {
    OFS_PRESET_A,
    OFS_PRESET_B,
    OFS_PARALLEL,
    OFS_SERIAL
  } dcfm_ofs_mode_type;
  // ==================================================================
  // one port's inputs, sampled together at the clock edge
  typedef struct packed {
    logic select_n; // port chip select, low active
    logic enable; // port enable
    logic write_not_read; // high writes into the device
    logic mailbox_pick; // high targets a mailbox
    logic [DATA_W-1:0] bus_in; // level seen on the data pins
  } dcfm_port_req_type;
endpackage
`default_nettype wire

//--- core/dcfm_top.sv
// mailbox fifo: staging buffer and device top in one file
`timescale 1ns/1ps
`default_nettype none

// ====================================================================
// staging fifo: width and depth shape the storage
module dcfm_stage_fifo #(
  parameter int W = dcfm_pkg::DATA_W,
  parameter int D = dcfm_pkg::STAGE_DEPTH
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data,
  output logic [$clog2(D):0] o_level
);
  localparam int AW = $clog2(D);
  // elaboration check: pointer wrap needs a power of two
  if (D < 2 || (1 << AW) != D)
  begin : g_bad_depth
    $error("stage depth must be a power of two");
  end

  // all state of the buffer
  typedef struct packed {
    logic [D-1:0][W-1:0] mem; // word slots
    logic [AW:0] wr; // write pointer with wrap bit
    logic [AW:0] rd; // read pointer with wrap bit
  } dcfm_stage_state_type;

  dcfm_stage_state_type st_q;
  dcfm_stage_state_type st_d;
  logic [AW:0] level; // words held
  logic push; // word taken in
  logic pop; // word handed on

  assign level = st_q.wr - st_q.rd;
  assign o_level = level;
  assign o_in_ready = (level != (AW+1)'(D)); // honest full
  assign o_out_valid = (level != '0); // honest empty
  assign o_out_data = st_q.mem[st_q.rd[AW-1:0]];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // next state: push and pop may share one edge
  always_comb
  begin
    st_d = st_q;
    if (push)
    begin
      st_d.mem[st_q.wr[AW-1:0]] = i_in_data;
      st_d.wr = st_q.wr + 1'b1;
    end
    if (pop)
    begin
      st_d.rd = st_q.rd + 1'b1;
    end
    if (i_sys_rst)
    begin
      // pointers only; stale words are unreachable
      st_d.wr = '0;
      st_d.rd = '0;
    end
  end

  // state register
  always_ff @(posedge i_core_clk)
  begin
    st_q <= st_d;
  end
endmodule // dcfm_stage_fifo

// ====================================================================
// device top: source port, array, sink port, mailboxes
module dcfm_top #(
  parameter int DEPTH = dcfm_pkg::DEPTH_DEF,
  parameter int PRESET_A = dcfm_pkg::PRESET_A,
  parameter int PRESET_B = dcfm_pkg::PRESET_B
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire dcfm_pkg::dcfm_port_req_type i_source,
  output logic [dcfm_pkg::DATA_W-1:0] o_source_bus_out,
  output logic o_source_bus_oe,
  input wire dcfm_pkg::dcfm_port_req_type i_sink,
  output logic [dcfm_pkg::DATA_W-1:0] o_sink_bus_out,
  output logic o_sink_bus_oe,
  input wire logic i_offset_sel1_serial_en_n,
  input wire logic i_offset_sel0_serial_bit,
  input wire logic i_retx_mode,
  input wire logic i_retx_rewind,
  output logic o_write_room_flag,
  output logic o_read_valid_flag,
  output logic o_near_full_flag_n,
  output logic o_near_empty_flag_n,
  output logic o_mail_in_flag_n,
  output logic o_mail_out_flag_n,
  output logic o_offsets_loaded
);
  localparam int DW = dcfm_pkg::DATA_W;
  localparam int AW = $clog2(DEPTH); // offset and index width
  localparam int SW = 2 * AW; // serial bits
  localparam int SDW = dcfm_pkg::STAGE_DEPTH;

  // elaboration check on the array depth
  if (DEPTH < 4 || (1 << AW) != DEPTH || PRESET_A >= DEPTH ||
      PRESET_B >= DEPTH)
  begin : g_bad_depth
    $error("depth must be a power of two above presets");
  end

  // all state of the device but the fifo array and the staging buffer
  typedef struct packed {
    logic [AW:0] wr; // array write pointer
    logic [AW:0] rd; // array read pointer
    logic [AW:0] mark; // retransmit start word
    logic retx_on; // retransmit mode active
    dcfm_pkg::dcfm_ofs_mode_type mode; // offset method
    logic ofs_done; // offsets programmed
    logic par_second; // next parallel word is near full
    logic [$clog2(SW+1)-1:0] bits; // serial bits taken
    logic [SW-1:0] ofs; // {near full, near empty}
    logic [DW-1:0] fwd_mbox; // source to sink mail
    logic [DW-1:0] ret_mbox; // sink to source mail
    logic [DW-1:0] sink_word; // last fifo word read
    logic mail_in_n; // forward mail waiting, low
    logic mail_out_n; // return mail waiting, low
    logic [1:0] room_s; // flag stages, source side
    logic [1:0] nfull_s;
    logic [1:0] valid_s; // flag stages, sink side
    logic [1:0] nempty_s;
  } dcfm_state_type;

  dcfm_state_type st_q;
  dcfm_state_type st_d;
  logic [DW-1:0] mem [DEPTH]; // the fifo array

  // ==================================================================
  // port qualifiers
  logic src_go; // qualified source edge
  logic snk_go; // qualified sink edge
  logic src_fifo_wr; // source word offered to fifo
  logic snk_fifo_rd; // sink pops a word
  logic [AW:0] count; // words stored
  logic [AW:0] used; // words that may not be overwritten
  logic [AW:0] free; // locations writable
  logic arr_full; // no writable location
  logic stg_in_ready;
  logic stg_valid;
  logic stg_pop;
  logic [DW-1:0] stg_data;
  logic [$clog2(SDW):0] stg_level;
  logic room_raw; // room before the flag stages

  assign src_go = !i_source.select_n && i_source.enable;
  assign snk_go = !i_sink.select_n && i_sink.enable;
  // parallel load takes the first source words, not the fifo
  assign src_fifo_wr = src_go && i_source.write_not_read &&
                       !i_source.mailbox_pick && st_q.room_s[1] &&
                       st_q.ofs_done;
  assign snk_fifo_rd = snk_go && !i_sink.write_not_read &&
                       !i_sink.mailbox_pick && st_q.valid_s[1] &&
                       (count != '0);
  assign count = st_q.wr - st_q.rd;
  // while retransmitting, words from the mark on are kept
  assign used = st_q.retx_on ? (st_q.wr - st_q.mark) : count;
  assign free = (AW+1)'(DEPTH) - used;
  assign arr_full = (free == '0);
  assign stg_pop = stg_valid && !arr_full;
  // slack covers flag lag; parallel offset words need room too
  assign room_raw = (st_q.ofs_done || st_q.mode == dcfm_pkg::OFS_PARALLEL)
    && (stg_level < ($clog2(SDW)+1)'(SDW - dcfm_pkg::STAGE_SLACK));

  // ==================================================================
  // staging buffer between source port and array
  dcfm_stage_fifo #(
    .W(DW),
    .D(SDW)
  ) u_stage (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(src_fifo_wr),
    .o_in_ready(stg_in_ready),
    .i_in_data(i_source.bus_in),
    .o_out_valid(stg_valid),
    .i_out_ready(!arr_full), // full array stalls draining
    .o_out_data(stg_data),
    .o_level(stg_level)
  );

  // ==================================================================
  // array write port
  always_ff @(posedge i_core_clk)
  begin
    if (stg_pop)
    begin
      mem[st_q.wr[AW-1:0]] <= stg_data;
    end
  end

  // ==================================================================
  // next state of the device
  always_comb
  begin
    st_d = st_q;
    // array pointers
    if (stg_pop)
    begin
      st_d.wr = st_q.wr + 1'b1;
    end
    // retransmit: mark taken on entry, rewind beats a pop
    if (i_retx_mode && !st_q.retx_on)
    begin
      st_d.retx_on = 1'b1;
      st_d.mark = st_q.rd;
    end
    else if (!i_retx_mode)
    begin
      st_d.retx_on = 1'b0;
    end
    if (st_q.retx_on && i_retx_rewind && snk_go)
    begin
      st_d.rd = st_q.mark;
    end
    else if (snk_fifo_rd)
    begin
      st_d.sink_word = mem[st_q.rd[AW-1:0]];
      st_d.rd = st_q.rd + 1'b1;
    end
    // offset programming
    if (!st_q.ofs_done)
    begin
      unique case (st_q.mode)
        dcfm_pkg::OFS_SERIAL:
        begin
          // only a core clock edge with serial enable low shifts
          if (!i_offset_sel1_serial_en_n)
          begin
            st_d.ofs = {st_q.ofs[SW-2:0],
                        i_offset_sel0_serial_bit};
            st_d.bits = st_q.bits + 1'b1;
            if (st_q.bits == ($clog2(SW+1))'(SW - 1))
            begin
              st_d.ofs_done = 1'b1;
            end
          end
        end
        dcfm_pkg::OFS_PARALLEL:
        begin
          // first word near empty, second near full
          if (src_go && i_source.write_not_read &&
              !i_source.mailbox_pick)
          begin
            if (st_q.par_second)
            begin
              st_d.ofs[SW-1:AW] = i_source.bus_in[AW-1:0];
              st_d.ofs_done = 1'b1;
            end
            else
            begin
              st_d.ofs[AW-1:0] = i_source.bus_in[AW-1:0];
              st_d.par_second = 1'b1;
            end
          end
        end
        default:
        begin
          // presets are loaded in reset; nothing to wait for
          st_d.ofs_done = 1'b1;
        end
      endcase
    end
    // mailboxes: clear first, so a same edge set wins
    if (snk_go && !i_sink.write_not_read && i_sink.mailbox_pick)
    begin
      st_d.mail_in_n = 1'b1;
    end
    if (src_go && i_source.write_not_read && i_source.mailbox_pick)
    begin
      st_d.fwd_mbox = i_source.bus_in;
      st_d.mail_in_n = 1'b0;
    end
    if (src_go && !i_source.write_not_read && i_source.mailbox_pick)
    begin
      st_d.mail_out_n = 1'b1;
    end
    if (snk_go && i_sink.write_not_read && i_sink.mailbox_pick)
    begin
      st_d.ret_mbox = i_sink.bus_in;
      st_d.mail_out_n = 1'b0;
    end
    // flags through two stages on the core clock
    st_d.room_s = {st_q.room_s[0], room_raw};
    st_d.nfull_s = {st_q.nfull_s[0],
                    !(free <= {1'b0, st_q.ofs[SW-1:AW]})};
    st_d.valid_s = {st_q.valid_s[0], (count != '0)};
    st_d.nempty_s = {st_q.nempty_s[0],
                     !(count <= {1'b0, st_q.ofs[AW-1:0]})};
    // reset: caller holds it four edges, straps read each edge
    if (i_sys_rst)
    begin
      st_d.wr = '0;
      st_d.rd = '0;
      st_d.mark = '0;
      st_d.retx_on = 1'b0;
      st_d.ofs_done = 1'b0;
      st_d.par_second = 1'b0;
      st_d.bits = '0;
      st_d.sink_word = '0;
      st_d.fwd_mbox = '0;
      st_d.ret_mbox = '0;
      st_d.mail_in_n = dcfm_pkg::RST_MAIL_N;
      st_d.mail_out_n = dcfm_pkg::RST_MAIL_N;
      st_d.room_s = {2{dcfm_pkg::RST_ROOM}};
      st_d.nfull_s = {2{dcfm_pkg::RST_NEAR_FULL_N}};
      st_d.valid_s = {2{dcfm_pkg::RST_VALID}};
      st_d.nempty_s = {2{dcfm_pkg::RST_NEAR_EMPTY_N}};
      // strap decode; last value before release stands
      unique case ({i_offset_sel1_serial_en_n,
                    i_offset_sel0_serial_bit})
        2'h0:
        begin
          st_d.mode = dcfm_pkg::OFS_PRESET_A;
          st_d.ofs = {AW'(PRESET_A), AW'(PRESET_A)};
        end
        2'h1:
        begin
          st_d.mode = dcfm_pkg::OFS_PRESET_B;
          st_d.ofs = {AW'(PRESET_B), AW'(PRESET_B)};
        end
        2'h2:
        begin
          st_d.mode = dcfm_pkg::OFS_PARALLEL;
          st_d.ofs = '0;
        end
        2'h3:
        begin
          st_d.mode = dcfm_pkg::OFS_SERIAL;
          st_d.ofs = '0;
        end
      endcase
    end
  end

  // state register; reset is folded into the next state
  always_ff @(posedge i_core_clk)
  begin
    st_q <= st_d;
  end

  // ==================================================================
  // outputs
  // buses drive only when selected and being read
  assign o_source_bus_oe = !i_source.select_n &&
                           !i_source.write_not_read;
  assign o_source_bus_out = st_q.ret_mbox;
  assign o_sink_bus_oe = !i_sink.select_n &&
                         !i_sink.write_not_read;
  assign o_sink_bus_out = i_sink.mailbox_pick ? st_q.fwd_mbox
                                              : st_q.sink_word;
  assign o_write_room_flag = st_q.room_s[1] && stg_in_ready;
  assign o_near_full_flag_n = st_q.nfull_s[1];
  assign o_read_valid_flag = st_q.valid_s[1];
  assign o_near_empty_flag_n = st_q.nempty_s[1];
  assign o_mail_in_flag_n = st_q.mail_in_n;
  assign o_mail_out_flag_n = st_q.mail_out_n;
  assign o_offsets_loaded = st_q.ofs_done;
endmodule // dcfm_top
`default_nettype wire

//--- bench/dcfm_bus_host.sv
// far-side port host: resolves one shared 36-bit data bus
`timescale 1ns/1ps
`default_nettype none
// ====================================================================
// bus end of a processor on one port
module dcfm_bus_host (
  input wire logic i_core_clk,
  input wire logic i_host_oe,
  input wire logic [dcfm_pkg::DATA_W-1:0] i_host_data,
  input wire logic i_dev_oe,
  input wire logic [dcfm_pkg::DATA_W-1:0] i_dev_data,
  output logic [dcfm_pkg::DATA_W-1:0] o_level
);
  // last level on the wires, kept so a floating bus keeps moving
  logic [dcfm_pkg::DATA_W-1:0] last_q = '0;
  always_ff @(posedge i_core_clk)
  begin
    last_q <= o_level;
  end
  // host first, then device; released bus toggles, never holds
  always_comb
  begin
    if (i_host_oe)
      o_level = i_host_data;
    else if (i_dev_oe)
      o_level = i_dev_data;
    else
      o_level = ~last_q;
  end
endmodule // dcfm_bus_host
`default_nettype wire

//--- bench/dcfm_properties.sv
// port checker of the mailbox fifo, bound into the device top
`timescale 1ns/1ps
`default_nettype none
// ====================================================================
// checker module
module dcfm_checker (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire dcfm_pkg::dcfm_port_req_type i_source,
  input wire dcfm_pkg::dcfm_port_req_type i_sink,
  input wire logic o_source_bus_oe,
  input wire logic [dcfm_pkg::DATA_W-1:0] o_sink_bus_out,
  input wire logic o_sink_bus_oe,
  input wire logic o_write_room_flag,
  input wire logic o_read_valid_flag,
  input wire logic o_near_full_flag_n,
  input wire logic o_near_empty_flag_n,
  input wire logic o_mail_in_flag_n,
  input wire logic o_mail_out_flag_n,
  input wire logic o_offsets_loaded
);
  // qualified edges and mailbox accesses per port
  logic src_go, snk_go, src_mbw, src_mbr, snk_mbw, snk_mbr;
  assign src_go = !i_source.select_n && i_source.enable;
  assign snk_go = !i_sink.select_n && i_sink.enable;
  assign src_mbw = src_go && i_source.write_not_read && i_source.mailbox_pick;
  assign src_mbr = src_go && !i_source.write_not_read && i_source.mailbox_pick;
  assign snk_mbw = snk_go && i_sink.write_not_read && i_sink.mailbox_pick;
  assign snk_mbr = snk_go && !i_sink.write_not_read && i_sink.mailbox_pick;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  // ==================================================================
  // named steps of the release sequence
  sequence s_release;
    $fell(i_sys_rst);
  endsequence
  sequence s_room_held;
    !o_write_room_flag [*2];
  endsequence
  // ==================================================================
  // assertions
  a_src_bus_drive: assert property (
    o_source_bus_oe == (!i_source.select_n && !i_source.write_not_read))
    else $error("source bus enable wrong");
  a_snk_bus_drive: assert property (
    o_sink_bus_oe == (!i_sink.select_n && !i_sink.write_not_read))
    else $error("sink bus enable wrong");
  a_mail_in_set: assert property (
    src_mbw |=> !o_mail_in_flag_n) else $error("mail in flag not set");
  a_mail_in_clear: assert property (
    snk_mbr && !src_mbw |=> o_mail_in_flag_n)
    else $error("mail in flag not released");
  a_mail_out_set: assert property (
    snk_mbw |=> !o_mail_out_flag_n) else $error("mail out flag not set");
  a_mail_out_clear: assert property (
    src_mbr && !snk_mbw |=> o_mail_out_flag_n)
    else $error("mail out flag not released");
  a_reset_flags: assert property (disable iff (1'b0)
    i_sys_rst |=> !o_write_room_flag && !o_read_valid_flag &&
    !o_near_empty_flag_n && o_near_full_flag_n && o_mail_in_flag_n &&
    o_mail_out_flag_n) else $error("reset flag levels wrong");
  a_room_late: assert property (
    s_release |-> s_room_held) else $error("room flag rose too early");
  a_room_rises: assert property (
    $rose(o_offsets_loaded) |-> ##[0:4] o_write_room_flag)
    else $error("room flag never rose");
  a_sink_hold: assert property (
    !snk_go && !i_sink.mailbox_pick ##1 !i_sink.mailbox_pick |->
    $stable(o_sink_bus_out)) else $error("sink word moved unqualified");
endmodule // dcfm_checker
bind dcfm_top dcfm_checker u_chk (
  .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_source(i_source),
  .i_sink(i_sink), .o_source_bus_oe(o_source_bus_oe),
  .o_sink_bus_out(o_sink_bus_out), .o_sink_bus_oe(o_sink_bus_oe),
  .o_write_room_flag(o_write_room_flag),
  .o_read_valid_flag(o_read_valid_flag),
  .o_near_full_flag_n(o_near_full_flag_n),
  .o_near_empty_flag_n(o_near_empty_flag_n),
  .o_mail_in_flag_n(o_mail_in_flag_n),
  .o_mail_out_flag_n(o_mail_out_flag_n),
  .o_offsets_loaded(o_offsets_loaded));
`default_nettype wire

//--- bench/testbench.sv
// self-checking bench of the mailbox fifo
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int DEPTH = 512;
  localparam int AW = $clog2(DEPTH);
  localparam int W = dcfm_pkg::DATA_W;
  localparam dcfm_pkg::dcfm_port_req_type IDLE =
    '{1'b1, 1'b0, 1'b0, 1'b0, 36'h0};
  // chosen offsets for parallel and serial loads
  localparam int PNE = 5, PNF = 508, SNE = 3, SNF = 510;
  int ne[4] = '{dcfm_pkg::PRESET_A, dcfm_pkg::PRESET_B, PNE, SNE};
  int nf[4] = '{dcfm_pkg::PRESET_A, dcfm_pkg::PRESET_B, PNF, SNF};
  logic i_core_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic sel1 = 1'b0, sel0 = 1'b0, retx = 1'b0, rew = 1'b0, wq = 1'b0;
  dcfm_pkg::dcfm_port_req_type src_c = IDLE, snk_c = IDLE, src_r, snk_r;
  logic [W-1:0] a_lvl, b_lvl, a_out, b_out, d, e;
  logic [W-1:0] w[3];
  logic a_oe, b_oe, room, valid, nf_n, ne_n, mi_n, mo_n, loaded;
  logic [W-1:0] q[$]; // words expected at the sink, in order
  logic [3:0] wpipe = 4'h0; // write to read-valid latency
  int avail = 0, n_fail = 0, checks_done = 0, cyc = 0;
  always #5 i_core_clk = ~i_core_clk;
  // ==================================================================
  // hosts on both ports and the device
  dcfm_bus_host u_host_a (.i_core_clk(i_core_clk),
    .i_host_oe(!src_c.select_n && src_c.write_not_read),
    .i_host_data(src_c.bus_in), .i_dev_oe(a_oe), .i_dev_data(a_out),
    .o_level(a_lvl));
  dcfm_bus_host u_host_b (.i_core_clk(i_core_clk),
    .i_host_oe(!snk_c.select_n && snk_c.write_not_read),
    .i_host_data(snk_c.bus_in), .i_dev_oe(b_oe), .i_dev_data(b_out),
    .o_level(b_lvl));
  always_comb
  begin
    src_r = src_c;
    src_r.bus_in = a_lvl;
    snk_r = snk_c;
    snk_r.bus_in = b_lvl;
  end
  dcfm_top #(.DEPTH(DEPTH)) uut (.i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst), .i_source(src_r), .o_source_bus_out(a_out),
    .o_source_bus_oe(a_oe), .i_sink(snk_r), .o_sink_bus_out(b_out),
    .o_sink_bus_oe(b_oe), .i_offset_sel1_serial_en_n(sel1),
    .i_offset_sel0_serial_bit(sel0), .i_retx_mode(retx),
    .i_retx_rewind(rew), .o_write_room_flag(room), .o_read_valid_flag(valid),
    .o_near_full_flag_n(nf_n), .o_near_empty_flag_n(ne_n),
    .o_mail_in_flag_n(mi_n), .o_mail_out_flag_n(mo_n),
    .o_offsets_loaded(loaded));
  // ==================================================================
  // reporting and compare tasks
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk_w(input logic [W-1:0] got, input logic [W-1:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    chk_w({35'h0, got}, {35'h0, exp});
  endtask
  // ==================================================================
  // drivers: one step after each rising edge
  task automatic tick;
    @(posedge i_core_clk);
    #1;
    avail += int'(wpipe[3]);
    wpipe = {wpipe[2:0], wq};
    wq = 1'b0;
  endtask
  function automatic logic [W-1:0] rnd;
    logic [63:0] t;
    t = {$urandom(), $urandom()};
    return t[W-1:0];
  endfunction
  task automatic do_reset(input logic [1:0] m);
    i_sys_rst = 1'b1;
    {sel1, sel0} = m;
    repeat (4) tick;
    i_sys_rst = 1'b0;
    q.delete();
    avail = 0;
    wpipe = 4'h0;
  endtask
  // source write, waits for room; fifo words enter the scoreboard
  task automatic wr(input logic pick, input logic [W-1:0] v, input bit fifo);
    while (!room) tick;
    src_c = '{1'b0, 1'b1, 1'b1, pick, v};
    wq = fifo;
    if (fifo)
      q.push_back(v);
    tick;
    src_c = IDLE;
    tick;
  endtask
  task automatic rd(input logic [W-1:0] exp);
    while (!valid) tick;
    snk_c = '{1'b0, 1'b1, 1'b0, 1'b0, 36'h0};
    tick;
    snk_c = IDLE;
    chk_w(b_out, exp);
    tick;
  endtask
  // serial offsets, near-full msb first; one bit short must not load
  task automatic ser_load;
    logic [2*AW-1:0] bits;
    bits = {AW'(SNF), AW'(SNE)};
    for (int i = 2*AW-1; i >= 0; i--)
    begin
      sel1 = 1'b0;
      sel0 = bits[i];
      tick;
      if (i < 2)
      begin
        sel1 = 1'b1;
        repeat (2) tick;
        chk_b(loaded, i == 0);
      end
    end
  endtask
  // random traffic; half of accesses lack select or enable
  task automatic run(input int wp, input int rp, input int n);
    dcfm_pkg::dcfm_port_req_type a, b;
    logic [W-1:0] exp;
    bit pend;
    int s;
    pend = 0;
    repeat (n)
    begin
      if (pend)
        chk_w(b_out, exp);
      pend = 0;
      a = IDLE;
      b = IDLE;
      s = $urandom % 4;
      if (room && $urandom % 100 < wp)
      begin
        a = '{s == 0, s != 1, 1'b1, 1'b0, rnd()};
        if (s > 1)
        begin
          q.push_back(a.bus_in);
          wq = 1'b1;
        end
      end
      s = $urandom % 4;
      if (avail > 0 && $urandom % 100 < rp)
      begin
        b = '{s == 0, s != 1, 1'b0, 1'b0, 36'h0};
        if (s > 1)
        begin
          exp = q.pop_front();
          avail--;
          pend = 1;
        end
      end
      src_c = a;
      snk_c = b;
      tick;
    end
    if (pend)
      chk_w(b_out, exp);
    // leave both ports idle so no stray access follows
    src_c = IDLE;
    snk_c = IDLE;
    tick;
  endtask
  // ==================================================================
  // hang guard
  always @(posedge i_core_clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      n_fail++;
      stop_test;
    end
  end
  // ==================================================================
  // main sequence
  initial
  begin
    void'($urandom(71369));
    for (int m = 3; m >= 0; m--)
    begin
      do_reset(2'(m));
      if (m == 2)
      begin
        wr(1'b0, W'(PNE), 1'b0);
        wr(1'b0, W'(PNF), 1'b0);
      end
      if (m == 3)
        ser_load;
      for (int k = 1; k <= ne[m] + 1; k++)
      begin
        wr(1'b0, rnd(), 1'b1);
        repeat (6) tick;
        chk_b(ne_n, k > ne[m]);
        chk_b(nf_n, DEPTH - k > nf[m]);
      end
      $display("test offsets done");
    end
    d = rnd();
    e = rnd();
    src_c = '{1'b0, 1'b0, 1'b1, 1'b1, d};
    tick;
    src_c = IDLE;
    tick;
    chk_b(mi_n, 1'b1);
    wr(1'b1, d, 1'b0);
    chk_b(mi_n, 1'b0);
    snk_c = '{1'b0, 1'b0, 1'b0, 1'b1, 36'h0};
    tick;
    chk_w(b_out, d);
    chk_b(mi_n, 1'b0);
    snk_c.enable = 1'b1;
    tick;
    snk_c = '{1'b0, 1'b1, 1'b1, 1'b1, e};
    chk_b(mi_n, 1'b1);
    tick;
    snk_c = IDLE;
    chk_b(mo_n, 1'b0);
    src_c = '{1'b0, 1'b1, 1'b0, 1'b1, 36'h0};
    tick;
    src_c = IDLE;
    chk_w(a_out, e);
    chk_b(mo_n, 1'b1);
    $display("test mailbox done");
    tick;
    run(100, 0, 1300);
    chk_b(room, 1'b0);
    chk_b(nf_n, 1'b0);
    chk_b(q.size() >= DEPTH && q.size() <= DEPTH + 8, 1'b1);
    run(50, 50, 400);
    run(0, 100, 1400);
    chk_b(q.size() == 0, 1'b1);
    $display("test traffic done");
    retx = 1'b1;
    tick;
    for (int i = 0; i < 3; i++)
    begin
      w[i] = rnd();
      wr(1'b0, w[i], 1'b1);
    end
    for (int i = 0; i < 3; i++)
      rd(q.pop_front());
    snk_c = '{1'b0, 1'b1, 1'b0, 1'b0, 36'h0};
    rew = 1'b1;
    tick;
    snk_c = IDLE;
    rew = 1'b0;
    tick;
    for (int i = 0; i < 3; i++)
      rd(w[i]);
    $display("test retransmit done");
    stop_test;
  end
endmodule // testbench
`default_nettype wire
